// ==== core/fbsm_memory_map.v ====
// fieldbus slave memory map: latch area, internal ram, wrap guard
//
// How it works
// - host latches and registers occupy the lowest addresses 00H to 15H
// - ram cells under the latch area are reachable by the sequencer only
// - organizational block of 42 bytes at 16H is host readable and writable
// - ram is 192 segments of 8 bytes; byte address is segment times 8
// - host access past memory end is moved down by 400H
// - every such wrap raises the ram access violation request
// - sequencer overrun wraps the same way and raises the same request
// - latch addresses 02H to 05H and 08H to 0BH have separate read-only and write-only cells
// - motorola mode flips address bit 0 for words at 00H to 07H
// - read of 09H hands over an input buffer, returns 2-bit result
// - read of 0BH fetches newest output buffer, returns 2-bit result
// - diag assignment reads at 0CH; read of 0DH hands over diag buffer
// - reads of 0EH and 0FH accept or reject user parameter data
// - reads of 10H and 11H accept or reject configuration data
// - read of 14H releases the slave address setting buffer
// - writes to word at 06H load the operating mode word
// - write to 0AH loads the baud watch root value
// - bus mode 0 selects motorola bus, 1 selects intel bus
`timescale 1ns/1ps
`include "fbsm_consts.vh"
module fbsm_memory_map #(
	parameter AW = `FBSM_AW,
	parameter RAM_BYTES = `FBSM_RAM_BYTES
) (
	input  wire          MCLK,
	input  wire          RST_N,
	input  wire          CLK_EN,
	input  wire          BUS_MODE,
	input  wire [AW-1:0] HOST_ADDR,
	input  wire [7:0]    HOST_WDATA,
	input  wire          HOST_WR,
	input  wire          HOST_RD,
	output reg  [7:0]    HOST_RDATA,
	output reg           HOST_RVALID,
	input  wire [7:0]    SEQ_SEG,
	input  wire [7:0]    SEQ_OFS,
	input  wire [7:0]    SEQ_WDATA,
	input  wire          SEQ_WR,
	input  wire          SEQ_RD,
	output reg  [7:0]    SEQ_RDATA,
	input  wire [15:0]   IRQ_EVENT,
	output wire          IRQ_N,
	input  wire [15:0]   STATUS_WORD,
	input  wire [7:0]    IN_BUF_STATE,
	input  wire [7:0]    OUT_BUF_STATE,
	input  wire [3:0]    DIAG_BUF_STATE,
	input  wire [1:0]    IN_HAND_RESULT,
	input  wire [1:0]    OUT_FETCH_RESULT,
	input  wire [1:0]    DIAG_HAND_RESULT,
	input  wire [1:0]    PRM_RESULT,
	input  wire [1:0]    CFG_RESULT,
	output reg           IN_BUF_HANDOVER,
	output reg           OUT_BUF_FETCH,
	output reg           DIAG_BUF_HANDOVER,
	output reg           PARAM_ACCEPT,
	output reg           PARAM_REJECT,
	output reg           CONFIG_ACCEPT,
	output reg           CONFIG_REJECT,
	output reg           ADDR_BUF_RELEASE,
	output reg  [15:0]   OPERATING_MODE,
	output reg  [7:0]    MODE_BITS,
	output reg  [7:0]    BAUD_WATCH_ROOT,
	output reg  [7:0]    MIN_RESP_DELAY
);

	reg  [7:0]    ram [0:RAM_BYTES-1];
	reg  [15:0]   irq_req_reg;
	reg  [15:0]   irq_req_next;
	reg  [15:0]   irq_mask_reg;
	reg  [15:0]   irq_mask_next;
	reg  [AW-1:0] h_swap;
	reg  [AW-1:0] h_addr;
	reg           h_wrap;
	reg  [AW:0]   s_raw;
	reg  [AW:0]   s_sub;
	reg  [AW-1:0] s_addr;
	reg           s_wrap;
	reg           h_latch;
	reg  [7:0]    latch_rd;
	wire [15:0]   irq_pend;
	wire          h_rd_ram;
	wire          h_wr_ram;
	wire          h_rd_lat;
	wire          h_wr_lat;

	// host address: byte swap, then wrap guard
	always @* begin
		h_swap = HOST_ADDR;
		if (!BUS_MODE && HOST_ADDR < `FBSM_SWAP_END) begin
			h_swap = HOST_ADDR ^ {{(AW-1){1'b0}}, 1'b1};
		end
		h_wrap = (h_swap >= `FBSM_RAM_END);
		h_addr = h_swap;
		if (h_wrap) begin
			h_addr = h_swap - `FBSM_WRAP_SUB;
		end
		h_latch = (h_addr < `FBSM_LATCH_END);
	end

	// sequencer address: segment base plus offset, same wrap guard
	always @* begin
		// one spare bit so a segment pointer above 191 cannot roll over
		s_raw = {1'b0, SEQ_SEG, {`FBSM_SEG_SHIFT{1'b0}}} + {{(AW-7){1'b0}}, SEQ_OFS};
		s_sub = s_raw - {1'b0, `FBSM_WRAP_SUB};
		s_wrap = (s_raw >= {1'b0, `FBSM_RAM_END});
		s_addr = s_raw[AW-1:0];
		if (s_wrap) begin
			s_addr = s_sub[AW-1:0];
		end
	end

	// host never reaches ram under the latches
	assign h_rd_ram = HOST_RD && !h_latch;
	assign h_wr_ram = HOST_WR && !h_latch;
	assign h_rd_lat = HOST_RD && h_latch;
	assign h_wr_lat = HOST_WR && h_latch;

	// ram: host write wins over sequencer write to the same byte
	always @(posedge MCLK) begin
		if (CLK_EN) begin
			if (SEQ_WR && !(h_wr_ram && h_addr == s_addr)) begin
				ram[s_addr] <= SEQ_WDATA;
			end
			if (h_wr_ram) begin
				ram[h_addr] <= HOST_WDATA;
			end
		end
	end

	// read side of latch area, separate from the write cells except the request bytes at 00H and 01H
	always @* begin
		latch_rd = `FBSM_RESERVED_RD;
		if (h_addr == `FBSM_A_IRQ_REQ_LO) begin
			latch_rd = irq_req_reg[7:0];
		end else if (h_addr == `FBSM_A_IRQ_REQ_HI) begin
			latch_rd = irq_req_reg[15:8];
		end else if (h_addr == `FBSM_A_IRQ_PND_LO) begin
			latch_rd = irq_pend[7:0];
		end else if (h_addr == `FBSM_A_IRQ_PND_HI) begin
			latch_rd = irq_pend[15:8];
		end else if (h_addr == `FBSM_A_STAT_LO) begin
			latch_rd = STATUS_WORD[7:0];
		end else if (h_addr == `FBSM_A_STAT_HI) begin
			latch_rd = STATUS_WORD[15:8];
		end else if (h_addr == `FBSM_A_IN_ASSIGN) begin
			latch_rd = IN_BUF_STATE;
		end else if (h_addr == `FBSM_A_IN_HAND) begin
			latch_rd = {6'h00, IN_HAND_RESULT};
		end else if (h_addr == `FBSM_A_OUT_ASSIGN) begin
			latch_rd = OUT_BUF_STATE;
		end else if (h_addr == `FBSM_A_OUT_FETCH) begin
			latch_rd = {6'h00, OUT_FETCH_RESULT};
		end else if (h_addr == `FBSM_A_DIAG_ASSIGN) begin
			latch_rd = {4'h0, DIAG_BUF_STATE};
		end else if (h_addr == `FBSM_A_DIAG_HAND) begin
			latch_rd = {6'h00, DIAG_HAND_RESULT};
		end else if (h_addr == `FBSM_A_PRM_OK || h_addr == `FBSM_A_PRM_NOK) begin
			latch_rd = {6'h00, PRM_RESULT};
		end else if (h_addr == `FBSM_A_CFG_OK || h_addr == `FBSM_A_CFG_NOK) begin
			latch_rd = {6'h00, CFG_RESULT};
		end
	end

	// interrupt requests: events and violations set, ack clears, set wins
	always @* begin
		irq_req_next = irq_req_reg;
		irq_mask_next = irq_mask_reg;
		if (h_wr_lat && h_addr == `FBSM_A_IRQ_PND_LO) begin
			irq_req_next[7:0] = irq_req_reg[7:0] & ~HOST_WDATA;
		end
		if (h_wr_lat && h_addr == `FBSM_A_IRQ_PND_HI) begin
			irq_req_next[15:8] = irq_req_reg[15:8] & ~HOST_WDATA;
		end
		if (h_wr_lat && h_addr == `FBSM_A_IRQ_REQ_LO) begin
			irq_req_next[7:0] = irq_req_next[7:0] | HOST_WDATA;
		end
		if (h_wr_lat && h_addr == `FBSM_A_IRQ_REQ_HI) begin
			irq_req_next[15:8] = irq_req_next[15:8] | HOST_WDATA;
		end
		if (h_wr_lat && h_addr == `FBSM_A_STAT_LO) begin
			irq_mask_next[7:0] = HOST_WDATA;
		end
		if (h_wr_lat && h_addr == `FBSM_A_STAT_HI) begin
			irq_mask_next[15:8] = HOST_WDATA;
		end
		irq_req_next = irq_req_next | IRQ_EVENT;
		if ((h_wrap && (HOST_RD || HOST_WR)) || (s_wrap && (SEQ_RD || SEQ_WR))) begin
			irq_req_next[`FBSM_VIOL_BIT] = 1'b1;
		end
	end

	assign irq_pend = irq_req_reg & ~irq_mask_reg;
	assign IRQ_N = ~(|irq_pend);

	// latch writes, read data and command pulses
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_req_reg <= `FBSM_RST_WORD;
			irq_mask_reg <= `FBSM_RST_WORD;
			OPERATING_MODE <= `FBSM_RST_WORD;
			MODE_BITS <= `FBSM_RST_BYTE;
			BAUD_WATCH_ROOT <= `FBSM_RST_BYTE;
			MIN_RESP_DELAY <= `FBSM_RST_BYTE;
			HOST_RDATA <= `FBSM_RST_BYTE;
			HOST_RVALID <= 1'b0;
			SEQ_RDATA <= `FBSM_RST_BYTE;
			IN_BUF_HANDOVER <= 1'b0;
			OUT_BUF_FETCH <= 1'b0;
			DIAG_BUF_HANDOVER <= 1'b0;
			PARAM_ACCEPT <= 1'b0;
			PARAM_REJECT <= 1'b0;
			CONFIG_ACCEPT <= 1'b0;
			CONFIG_REJECT <= 1'b0;
			ADDR_BUF_RELEASE <= 1'b0;
		end else if (CLK_EN) begin
			irq_req_reg <= irq_req_next;
			irq_mask_reg <= irq_mask_next;
			if (h_wr_lat) begin
				if (h_addr == `FBSM_A_MODE0_LO) begin
					OPERATING_MODE[7:0] <= HOST_WDATA;
				end else if (h_addr == `FBSM_A_MODE0_HI) begin
					OPERATING_MODE[15:8] <= HOST_WDATA;
				end else if (h_addr == `FBSM_A_MODE1_SET) begin
					MODE_BITS <= MODE_BITS | HOST_WDATA;
				end else if (h_addr == `FBSM_A_MODE1_CLR) begin
					MODE_BITS <= MODE_BITS & ~HOST_WDATA;
				end else if (h_addr == `FBSM_A_BAUD_ROOT) begin
					BAUD_WATCH_ROOT <= HOST_WDATA;
				end else if (h_addr == `FBSM_A_MIN_DELAY) begin
					MIN_RESP_DELAY <= HOST_WDATA;
				end
			end
			HOST_RVALID <= HOST_RD;
			if (h_rd_lat) begin
				HOST_RDATA <= latch_rd;
			end else if (h_rd_ram) begin
				HOST_RDATA <= ram[h_addr];
			end
			if (SEQ_RD) begin
				SEQ_RDATA <= ram[s_addr];
			end
			IN_BUF_HANDOVER <= h_rd_lat && h_addr == `FBSM_A_IN_HAND;
			OUT_BUF_FETCH <= h_rd_lat && h_addr == `FBSM_A_OUT_FETCH;
			DIAG_BUF_HANDOVER <= h_rd_lat && h_addr == `FBSM_A_DIAG_HAND;
			PARAM_ACCEPT <= h_rd_lat && h_addr == `FBSM_A_PRM_OK;
			PARAM_REJECT <= h_rd_lat && h_addr == `FBSM_A_PRM_NOK;
			CONFIG_ACCEPT <= h_rd_lat && h_addr == `FBSM_A_CFG_OK;
			CONFIG_REJECT <= h_rd_lat && h_addr == `FBSM_A_CFG_NOK;
			ADDR_BUF_RELEASE <= h_rd_lat && h_addr == `FBSM_A_ADDR_REL;
		end
	end

endmodule

// ==== core/fbsm_consts.vh ====
// constants for the fieldbus slave memory map
`ifndef FBSM_CONSTS_VH
`define FBSM_CONSTS_VH
`define FBSM_AW            11
`define FBSM_RAM_BYTES     1536
`define FBSM_RAM_END       11'h600
`define FBSM_WRAP_SUB      11'h400
`define FBSM_LATCH_END     11'h016
`define FBSM_ORG_START     11'h016
`define FBSM_ORG_BYTES     42
`define FBSM_BUF_START     11'h040
`define FBSM_BUF_LAST      11'h5FF
`define FBSM_SEG_COUNT     192
`define FBSM_SEG_BYTES     8
`define FBSM_SEG_SHIFT     3
`define FBSM_SWAP_END      11'h008
`define FBSM_A_IRQ_REQ_LO  11'h000
`define FBSM_A_IRQ_REQ_HI  11'h001
`define FBSM_A_IRQ_PND_LO  11'h002
`define FBSM_A_IRQ_PND_HI  11'h003
`define FBSM_A_STAT_LO     11'h004
`define FBSM_A_STAT_HI     11'h005
`define FBSM_A_MODE0_LO    11'h006
`define FBSM_A_MODE0_HI    11'h007
`define FBSM_A_IN_ASSIGN   11'h008
`define FBSM_A_IN_HAND     11'h009
`define FBSM_A_OUT_ASSIGN  11'h00A
`define FBSM_A_OUT_FETCH   11'h00B
`define FBSM_A_DIAG_ASSIGN 11'h00C
`define FBSM_A_DIAG_HAND   11'h00D
`define FBSM_A_PRM_OK      11'h00E
`define FBSM_A_PRM_NOK     11'h00F
`define FBSM_A_CFG_OK      11'h010
`define FBSM_A_CFG_NOK     11'h011
`define FBSM_A_ADDR_REL    11'h014
`define FBSM_A_MODE1_SET   11'h008
`define FBSM_A_MODE1_CLR   11'h009
`define FBSM_A_BAUD_ROOT   11'h00A
`define FBSM_A_MIN_DELAY   11'h00B
`define FBSM_VIOL_BIT      4
`define FBSM_RST_WORD      16'h0000
`define FBSM_RST_BYTE      8'h00
`define FBSM_RESERVED_RD   8'h00
`endif

// ==== bench/fbsm_props.sv ====
// checker for the fieldbus slave memory map host ports
`timescale 1ns/1ps
module fbsm_props #(
	parameter AW = 11
) (
	input wire          MCLK,
	input wire          RST_N,
	input wire          CLK_EN,
	input wire          BUS_MODE,
	input wire [AW-1:0] HOST_ADDR,
	input wire [7:0]    HOST_WDATA,
	input wire          HOST_WR,
	input wire          HOST_RD,
	input wire [7:0]    HOST_RDATA,
	input wire [1:0]    IN_HAND_RESULT,
	input wire [1:0]    OUT_FETCH_RESULT,
	input wire          IN_BUF_HANDOVER,
	input wire          OUT_BUF_FETCH,
	input wire          DIAG_BUF_HANDOVER,
	input wire          PARAM_ACCEPT,
	input wire          PARAM_REJECT,
	input wire          CONFIG_ACCEPT,
	input wire          CONFIG_REJECT,
	input wire          ADDR_BUF_RELEASE,
	input wire [15:0]   OPERATING_MODE,
	input wire [7:0]    BAUD_WATCH_ROOT
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	wire [AW-1:0] ra = (CLK_EN && HOST_RD) ? HOST_ADDR : 11'h7FF;
	wire [AW-1:0] wa = (CLK_EN && HOST_WR) ? HOST_ADDR : 11'h7FF;
	property p_in_hand;
		ra == 11'h009 |=> IN_BUF_HANDOVER && HOST_RDATA == {6'h00, $past(IN_HAND_RESULT)};
	endproperty
	a_in_hand: assert property (p_in_hand) else $error("input handover wrong");
	property p_out_fetch;
		ra == 11'h00B |=> OUT_BUF_FETCH && HOST_RDATA == {6'h00, $past(OUT_FETCH_RESULT)};
	endproperty
	a_out_fetch: assert property (p_out_fetch) else $error("output fetch wrong");
	property p_diag;
		ra == 11'h00D |=> DIAG_BUF_HANDOVER ##1 !DIAG_BUF_HANDOVER;
	endproperty
	a_diag: assert property (p_diag) else $error("diag handover wrong");
	property p_prm;
		ra == 11'h00E |=> PARAM_ACCEPT && !PARAM_REJECT;
	endproperty
	a_prm: assert property (p_prm) else $error("param accept wrong");
	property p_prm_nok;
		ra == 11'h00F |=> PARAM_REJECT && !PARAM_ACCEPT;
	endproperty
	a_prm_nok: assert property (p_prm_nok) else $error("param reject wrong");
	property p_cfg;
		ra == 11'h010 |=> CONFIG_ACCEPT && !CONFIG_REJECT;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config accept wrong");
	property p_cfg_nok;
		ra == 11'h011 |=> CONFIG_REJECT && !CONFIG_ACCEPT;
	endproperty
	a_cfg_nok: assert property (p_cfg_nok) else $error("config reject wrong");
	property p_rel;
		ADDR_BUF_RELEASE |-> $past(ra) == 11'h014;
	endproperty
	a_rel: assert property (p_rel) else $error("release pulse without read");
	property p_baud;
		wa == 11'h00A |=> BAUD_WATCH_ROOT == $past(HOST_WDATA);
	endproperty
	a_baud: assert property (p_baud) else $error("baud root not loaded");
	property p_mode;
		wa == 11'h006 && BUS_MODE |=> OPERATING_MODE[7:0] == $past(HOST_WDATA);
	endproperty
	a_mode: assert property (p_mode) else $error("mode low byte not loaded");
	property p_swap;
		wa == 11'h006 && !BUS_MODE |=> OPERATING_MODE[15:8] == $past(HOST_WDATA);
	endproperty
	a_swap: assert property (p_swap) else $error("mode byte not swapped");
	property p_resv;
		ra == 11'h012 |=> HOST_RDATA == 8'h00 && !IN_BUF_HANDOVER;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved read not quiet");
	c_hand: cover property (ra == 11'h009);
	c_wrap: cover property (wa >= 11'h600 && wa != 11'h7FF);
	c_swap: cover property (wa == 11'h006 && !BUS_MODE);
endmodule
bind fbsm_memory_map fbsm_props #(.AW(AW)) u_props (.*);

// ==== bench/fbsm_host.sv ====
// host processor model driving the byte-wide register bus
`timescale 1ns/1ps
module fbsm_host (
	input  wire        mclk,
	output reg  [10:0] addr,
	output reg  [7:0]  wdata,
	output reg         wr,
	output reg         rd
);
	initial {addr, wdata, wr, rd} = 21'h000000;
	task acc(input [10:0] a, input [7:0] d, input w);
		begin
			@(negedge mclk);
			addr = a;
			wdata = d;
			wr = w;
			rd = !w;
			@(negedge mclk);
			wr = 1'b0;
			rd = 1'b0;
			addr = ~a;
			wdata = ~d;
		end
	endtask
endmodule

// ==== bench/fieldbus_slave_memory_map_bench.sv ====
// self-checking bench for the fieldbus slave memory map
`timescale 1ns/1ps
module fieldbus_slave_memory_map_bench;
	reg         mclk, rst_n, bus_mode, seq_wr, seq_rd;
	reg  [7:0]  seq_seg, seq_ofs, seq_wdata, in_st, out_st;
	reg  [15:0] irq_event, status;
	reg  [3:0]  diag_st;
	reg  [9:0]  res;
	reg  [31:0] seed, d;
	reg  [8:0]  qe;
	reg  [8:0]  q [$];
	integer     n_mismatch, comparisons, cyc;
	wire [10:0] ha;
	wire [7:0]  hd, rdata, seq_rdata, mbits, baud, mdly;
	wire [15:0] opmode;
	wire        hw, hr, rvalid, irq_n;
	fbsm_host h (.mclk(mclk), .addr(ha), .wdata(hd), .wr(hw), .rd(hr));
	fbsm_memory_map dut (.MCLK(mclk), .RST_N(rst_n), .CLK_EN(1'b1), .BUS_MODE(bus_mode),
		.HOST_ADDR(ha), .HOST_WDATA(hd), .HOST_WR(hw), .HOST_RD(hr), .HOST_RDATA(rdata),
		.HOST_RVALID(rvalid), .SEQ_SEG(seq_seg), .SEQ_OFS(seq_ofs), .SEQ_WDATA(seq_wdata),
		.SEQ_WR(seq_wr), .SEQ_RD(seq_rd), .SEQ_RDATA(seq_rdata), .IRQ_EVENT(irq_event),
		.IRQ_N(irq_n), .STATUS_WORD(status), .IN_BUF_STATE(in_st), .OUT_BUF_STATE(out_st),
		.DIAG_BUF_STATE(diag_st), .IN_HAND_RESULT(res[1:0]), .OUT_FETCH_RESULT(res[3:2]),
		.DIAG_HAND_RESULT(res[5:4]), .PRM_RESULT(res[7:6]), .CFG_RESULT(res[9:8]),
		.IN_BUF_HANDOVER(), .OUT_BUF_FETCH(), .DIAG_BUF_HANDOVER(), .PARAM_ACCEPT(),
		.PARAM_REJECT(), .CONFIG_ACCEPT(), .CONFIG_REJECT(), .ADDR_BUF_RELEASE(),
		.OPERATING_MODE(opmode), .MODE_BITS(mbits), .BAUD_WATCH_ROOT(baud),
		.MIN_RESP_DELAY(mdly));
	task chk(input [15:0] e, input [15:0] s, input string n);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0s exp %h got %h", n, e, s);
			end
		end
	endtask
	task rdc(input [10:0] a, input [8:0] e);
		begin
			q.push_back(e);
			h.acc(a, 8'h00, 1'b0);
		end
	endtask
	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
			if (n_mismatch == 0 && comparisons > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(negedge mclk) begin
		if (rvalid === 1'b1 && q.size() > 0) begin
			qe = q.pop_front();
			if (!qe[8])
				chk({8'h00, qe[7:0]}, {8'h00, rdata}, "read data");
		end
	end
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			end_sim;
		end
	end
	initial begin
		{n_mismatch, comparisons, cyc} = 96'h0;
		seed = 32'hcfec8e58;
		{rst_n, bus_mode, seq_wr, seq_rd, seq_seg, seq_ofs, seq_wdata, irq_event} = 44'h0;
		{status, in_st, out_st, diag_st, res} = {$random(seed), $random(seed)};
		d = $random(seed);
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		bus_mode = 1'b1;
		h.acc(11'h006, d[7:0], 1'b1);
		h.acc(11'h007, d[15:8], 1'b1);
		chk(d[15:0], opmode, "mode word");
		h.acc(11'h00A, d[23:16], 1'b1);
		chk({8'h00, d[23:16]}, {8'h00, baud}, "baud root");
		h.acc(11'h00B, d[31:24], 1'b1);
		chk({8'h00, d[31:24]}, {8'h00, mdly}, "min delay");
		h.acc(11'h008, 8'hFF, 1'b1);
		h.acc(11'h009, d[7:0], 1'b1);
		chk({8'h00, ~d[7:0]}, {8'h00, mbits}, "mode bits");
		h.acc(11'h012, 8'h5A, 1'b1);
		rdc(11'h012, 9'h000);
		rdc(11'h008, {1'b0, in_st});
		rdc(11'h009, {7'h00, res[1:0]});
		rdc(11'h00A, {1'b0, out_st});
		rdc(11'h00B, {7'h00, res[3:2]});
		rdc(11'h00C, {5'h00, diag_st});
		rdc(11'h00D, {7'h00, res[5:4]});
		rdc(11'h00E, {7'h00, res[7:6]});
		rdc(11'h00F, {7'h00, res[7:6]});
		rdc(11'h010, {7'h00, res[9:8]});
		rdc(11'h011, {7'h00, res[9:8]});
		rdc(11'h014, 9'h000);
		h.acc(11'h016, d[31:24], 1'b1);
		rdc(11'h016, {1'b0, d[31:24]});
		$display("latch map test done");
		bus_mode = 1'b0;
		h.acc(11'h006, 8'h5A, 1'b1);
		chk({8'h5A, d[7:0]}, opmode, "swapped mode");
		rdc(11'h005, {1'b0, status[7:0]});
		bus_mode = 1'b1;
		$display("bus mode test done");
		h.acc(11'h004, 8'h00, 1'b1);
		h.acc(11'h000, 8'h01, 1'b1);
		chk(16'h0000, {15'h0000, irq_n}, "irq low");
		rdc(11'h002, 9'h001);
		h.acc(11'h002, 8'h01, 1'b1);
		chk(16'h0001, {15'h0000, irq_n}, "irq cleared");
		h.acc(11'h004, 8'h02, 1'b1);
		@(negedge mclk) irq_event = 16'h0002;
		@(negedge mclk) irq_event = 16'h0000;
		chk(16'h0001, {15'h0000, irq_n}, "irq masked");
		rdc(11'h000, 9'h002);
		rdc(11'h002, 9'h000);
		h.acc(11'h002, 8'hFF, 1'b1);
		$display("interrupt test done");
		h.acc(11'h650, d[15:8], 1'b1);
		rdc(11'h250, {1'b0, d[15:8]});
		rdc(11'h000, 9'h010);
		h.acc(11'h002, 8'hFF, 1'b1);
		@(negedge mclk) {seq_seg, seq_ofs, seq_wdata, seq_wr} = {16'hC008, d[23:16], 1'b1};
		@(negedge mclk) seq_wr = 1'b0;
		rdc(11'h208, {1'b0, d[23:16]});
		rdc(11'h000, 9'h010);
		h.acc(11'h048, d[31:24], 1'b1);
		@(negedge mclk) {seq_seg, seq_ofs, seq_rd} = {16'h0900, 1'b1};
		@(negedge mclk) seq_rd = 1'b0;
		chk({8'h00, d[31:24]}, {8'h00, seq_rdata}, "segment read");
		$display("wrap test done");
		repeat (3) @(negedge mclk);
		end_sim;
	end
endmodule
